// file: inc/gmc_pkg.sv
package gmc_pkg;
  // ---------------------------------------------------------------
  // register placement
  // ---------------------------------------------------------------
  localparam logic [7:0]  GMC_CTRL_OFFSET  = 8'h52;       // byte offset of graphics_control
  localparam logic [5:0]  GMC_CTRL_DWORD   = GMC_CTRL_OFFSET[7:2]; // dword index holding it
  localparam int          GMC_CTRL_LANE    = 2;           // byte lane of its low byte
  localparam int          GMC_CTRL_SHIFT   = 16;          // bit position inside the dword
  localparam logic [15:0] GMC_CTRL_RESET   = 16'h0030;    // whole register after reset

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int          GMC_FBS_LSB      = 4;           // frame_buffer_size_select low bit
  localparam int          GMC_FBS_W        = 3;           // its width
  localparam int          GMC_LVD_BIT      = 1;           // legacy_video_disable bit
  localparam logic [2:0]  GMC_FBS_RESET    = 3'h3;        // 8 MB code
  localparam logic [0:0]  GMC_LVD_RESET    = 1'h0;        // legacy video claimed

  // ---------------------------------------------------------------
  // size codes and answers
  // ---------------------------------------------------------------
  localparam logic [2:0]  GMC_FBS_NONE     = 3'h0;        // nothing pre-allocated
  localparam logic [2:0]  GMC_FBS_1MB      = 3'h1;        // unified memory, 1 MB
  localparam logic [2:0]  GMC_FBS_8MB      = 3'h3;        // unified memory, 8 MB
  localparam logic [3:0]  GMC_MB_NONE      = 4'h0;        // size answer for none/reserved
  localparam logic [3:0]  GMC_MB_ONE       = 4'h1;        // size answer, 1 MB
  localparam logic [3:0]  GMC_MB_EIGHT     = 4'h8;        // size answer, 8 MB
  localparam logic [7:0]  GMC_SUBCLASS_VGA = 8'h00;       // graphics reports vga compatible
  localparam logic [7:0]  GMC_SUBCLASS_OTH = 8'h80;       // graphics reports other display
endpackage

// file: core/gmc_lock_field.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// lockable read/write field
// ---------------------------------------------------------------
module gmc_lock_field #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys_in,   // system clock
  input  wire logic         sys_rst_in,   // synchronous reset, high
  input  wire logic         wr_en_in,     // write strobe for this field
  input  wire logic         lock_in,      // lock, blocks writes
  input  wire logic [W-1:0] wdata_in,     // write value
  output logic      [W-1:0] q_out         // stored value
);
  logic [W-1:0] field_q;                  // stored field
  logic [W-1:0] field_d;                  // next value

  // next value: take write only while unlocked
  always_comb begin
    field_d = field_q;
    if (wr_en_in && !lock_in) begin
      field_d = wdata_in;
    end
  end

  // register stage
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      field_q <= RST;
    end else begin
      field_q <= field_d;
    end
  end

  assign q_out = field_q;
endmodule

// file: core/gmc_graphics_control.sv
`timescale 1ns/1ps
// What this block does
// - size select bits 6:4, resets to 8 MB
// - code zero: no memory, no vga, 80h
// - code one: unified memory, 1 MB
// - code three: 8 MB; other codes reserved
// - lock set: size and disable ignore writes
// - disable clear with a nonzero code: claim vga, report 00h
// - disable set: decline vga, report 80h
module gmc_graphics_control
  import gmc_pkg::*;
(
  input  wire logic        clk_sys_in,        // system clock, 25 MHz
  input  wire logic        sys_rst_in,        // synchronous reset, high
  input  wire logic [7:0]  cfg_addr_in,       // config byte address, dword aligned
  input  wire logic [3:0]  cfg_be_in,         // config byte enables
  input  wire logic        cfg_wr_in,         // config write strobe
  input  wire logic        cfg_rd_in,         // config read strobe
  input  wire logic [31:0] cfg_wdata_in,      // config write data
  input  wire logic        smm_region_lock_in, // lock from the smm ram register
  output logic      [31:0] cfg_rdata_out,     // config read data, registered
  output logic             cfg_rvalid_out,    // read data valid, one cycle
  output logic      [2:0]  frame_buffer_size_select_out, // stored size code
  output logic             legacy_video_disable_out,     // stored disable bit
  output logic             vga_claim_out,     // graphics claims vga cycles
  output logic      [7:0]  sub_class_out,     // graphics sub-class code
  output logic             unified_memory_out, // unified memory mode active
  output logic      [3:0]  prealloc_mb_out    // pre-allocated size in MB
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // size code to megabytes, reserved codes give nothing
  function automatic logic [3:0] gmc_size_mb(input logic [2:0] code);
    case (code)
      GMC_FBS_1MB: gmc_size_mb = GMC_MB_ONE;
      GMC_FBS_8MB: gmc_size_mb = GMC_MB_EIGHT;
      default:     gmc_size_mb = GMC_MB_NONE;   // none or reserved
    endcase
  endfunction

  // vga claimed only with a nonzero size code and disable clear
  function automatic logic gmc_claims(input logic [2:0] code, input logic dis);
    gmc_claims = !dis && (code != GMC_FBS_NONE);
  endfunction

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic        hit;                           // address selects our dword
  logic        lane_wr;                       // write reaches the low byte
  logic [15:0] wr_half;                       // register half of write data
  logic [2:0]  fbs_q;                         // size field
  logic        lvd_q;                         // disable field
  logic [2:0]  fbs_d;                         // size after this edge
  logic        lvd_d;                         // disable after this edge
  logic        fld_wr;                        // effective field write

  assign hit     = (cfg_addr_in[7:2] == GMC_CTRL_DWORD);
  assign lane_wr = cfg_wr_in && hit && cfg_be_in[GMC_CTRL_LANE];
  assign wr_half = cfg_wdata_in[GMC_CTRL_SHIFT +: 16];
  // upper byte lane holds only reserved bits, so its writes vanish
  assign fld_wr  = lane_wr && !smm_region_lock_in;

  // ---------------------------------------------------------------
  // field storage
  // ---------------------------------------------------------------
  gmc_lock_field #(
    .W   (GMC_FBS_W),
    .RST (GMC_FBS_RESET)
  ) u_fbs (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .wr_en_in   (lane_wr),
    .lock_in    (smm_region_lock_in),
    .wdata_in   (wr_half[GMC_FBS_LSB +: GMC_FBS_W]),
    .q_out      (fbs_q)
  );

  gmc_lock_field #(
    .W   (1),
    .RST (GMC_LVD_RESET)
  ) u_lvd (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .wr_en_in   (lane_wr),
    .lock_in    (smm_region_lock_in),
    .wdata_in   (wr_half[GMC_LVD_BIT]),
    .q_out      (lvd_q)
  );

  // next field values, mirrored so outputs track the fields
  always_comb begin
    fbs_d = fbs_q;
    lvd_d = lvd_q;
    if (fld_wr) begin
      fbs_d = wr_half[GMC_FBS_LSB +: GMC_FBS_W];
      lvd_d = wr_half[GMC_LVD_BIT];
    end
  end

  // ---------------------------------------------------------------
  // derived graphics state
  // ---------------------------------------------------------------
  logic       claim_q;                        // vga claim
  logic       claim_d;
  logic [7:0] sub_q;                          // sub-class
  logic [7:0] sub_d;
  logic       uma_q;                          // unified memory mode
  logic       uma_d;
  logic [3:0] mb_q;                           // allocated megabytes
  logic [3:0] mb_d;

  // decode the coming field values
  always_comb begin
    claim_d = gmc_claims(fbs_d, lvd_d);
    sub_d   = claim_d ? GMC_SUBCLASS_VGA : GMC_SUBCLASS_OTH;
    mb_d    = gmc_size_mb(fbs_d);
    uma_d   = (mb_d != GMC_MB_NONE);
  end

  // register derived state
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      claim_q <= gmc_claims(GMC_FBS_RESET, GMC_LVD_RESET);
      sub_q   <= GMC_SUBCLASS_VGA;
      mb_q    <= GMC_MB_EIGHT;
      uma_q   <= 1'b1;
    end else begin
      claim_q <= claim_d;
      sub_q   <= sub_d;
      mb_q    <= mb_d;
      uma_q   <= uma_d;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [31:0] rdata_q;                       // read data
  logic [31:0] rdata_d;
  logic        rvalid_q;                      // read answer strobe
  logic        rvalid_d;
  logic [15:0] ctrl_view;                     // register as software sees it

  // reserved bits built as zero
  always_comb begin
    ctrl_view = '0;
    ctrl_view[GMC_FBS_LSB +: GMC_FBS_W] = fbs_q;
    ctrl_view[GMC_LVD_BIT] = lvd_q;
    rdata_d  = '0;                            // unmapped reads zero
    rvalid_d = cfg_rd_in;
    if (cfg_rd_in && hit) begin
      rdata_d[GMC_CTRL_SHIFT +: 16] = ctrl_view;
    end
  end

  // register read answer
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign cfg_rdata_out                = rdata_q;
  assign cfg_rvalid_out               = rvalid_q;
  assign frame_buffer_size_select_out = fbs_q;
  assign legacy_video_disable_out     = lvd_q;
  assign vga_claim_out                = claim_q;
  assign sub_class_out                = sub_q;
  assign unified_memory_out           = uma_q;
  assign prealloc_mb_out              = mb_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_open_write;
    lane_wr && !smm_region_lock_in;
  endsequence

  sequence s_locked_write;
    lane_wr && smm_region_lock_in;
  endsequence

  // stored code that allocates nothing: none or reserved
  sequence s_no_alloc_code;
    fbs_q != GMC_FBS_1MB && fbs_q != GMC_FBS_8MB;
  endsequence

  // write data fields picked straight off the bus for the checks
  logic [GMC_FBS_W-1:0] chk_fbs_wr;           // size bits carried by the write
  logic                 chk_lvd_wr;           // disable bit carried by the write

  assign chk_fbs_wr = cfg_wdata_in[GMC_CTRL_SHIFT + GMC_FBS_LSB +: GMC_FBS_W];
  assign chk_lvd_wr = cfg_wdata_in[GMC_CTRL_SHIFT + GMC_LVD_BIT];

  a_reset_size_code: assert property ($past(sys_rst_in) |-> fbs_q == GMC_FBS_RESET && mb_q == GMC_MB_EIGHT)
    else $error("size code not 8 MB after reset");
  a_reset_vga_claim: assert property ($past(sys_rst_in) |-> lvd_q == GMC_LVD_RESET && vga_claim_out)
    else $error("vga not claimed after reset");
  a_zero_no_claim: assert property (fbs_q == 3'h0 |-> !vga_claim_out && sub_class_out == 8'h80)
    else $error("zero size code still claims vga");
  a_one_mb_uma: assert property (fbs_q == 3'h1 |-> prealloc_mb_out == 4'h1 && unified_memory_out)
    else $error("code one not 1 MB unified");
  a_eight_mb_uma: assert property (fbs_q == 3'h3 |-> prealloc_mb_out == 4'h8 && unified_memory_out)
    else $error("code three not 8 MB unified");
  a_locked_hold: assert property (s_locked_write |=> $stable(fbs_q) && $stable(lvd_q))
    else $error("locked register changed");
  a_open_write_take: assert property (s_open_write |=> fbs_q == $past(chk_fbs_wr) && lvd_q == $past(chk_lvd_wr))
    else $error("unlocked write not taken");
  a_miss_write_hold: assert property (cfg_wr_in && !lane_wr |=> $stable(fbs_q) && $stable(lvd_q))
    else $error("write outside the low byte changed the register");
  a_reserved_no_uma: assert property (s_no_alloc_code |-> !unified_memory_out)
    else $error("reserved code shows unified memory");
  a_reserved_no_mb: assert property (s_no_alloc_code |-> prealloc_mb_out == GMC_MB_NONE)
    else $error("reserved code pre-allocates memory");
  a_vga_claim_on: assert property (!lvd_q && fbs_q != 3'h0 |-> vga_claim_out && sub_class_out == 8'h00)
    else $error("vga not claimed with disable clear");
  a_vga_decline: assert property (lvd_q |-> !vga_claim_out && sub_class_out == 8'h80)
    else $error("vga claimed with disable set");
  a_reserved_zero: assert property (cfg_rvalid_out |-> cfg_rdata_out[31:23] == 9'h0
                                    && cfg_rdata_out[19:18] == 2'h0 && cfg_rdata_out[16] == 1'b0)
    else $error("reserved bits read nonzero");
endmodule

// file: tb/test_graphics_memory_control.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// self-checking bench for the graphics control register
// ---------------------------------------------------------------
module test_graphics_memory_control
  import gmc_pkg::*;
;
  // compare macro, counts every check and reports mismatches
  `define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp); end end

  logic        clk_sys_in;           // 25 MHz clock
  logic        sys_rst_in;           // synchronous reset, high
  logic [7:0]  cfg_addr_in;          // config byte address
  logic [3:0]  cfg_be_in;            // byte enables
  logic        cfg_wr_in;            // write strobe
  logic        cfg_rd_in;            // read strobe
  logic [31:0] cfg_wdata_in;         // write data
  logic        smm_region_lock_in;   // lock level
  logic [31:0] cfg_rdata_out;        // read data
  logic        cfg_rvalid_out;       // read valid pulse
  logic [2:0]  fbs_out;              // stored size code
  logic        lvd_out;              // stored disable bit
  logic        vga_claim_out;        // vga claim
  logic [7:0]  sub_class_out;        // sub-class code
  logic        uma_out;              // unified memory flag
  logic [3:0]  mb_out;               // pre-allocated MB
  int          errors;               // mismatch counter
  int          checks;               // comparison counter
  int          cycles;               // timeout counter

  gmc_graphics_control dut (
    .clk_sys_in                   (clk_sys_in),
    .sys_rst_in                   (sys_rst_in),
    .cfg_addr_in                  (cfg_addr_in),
    .cfg_be_in                    (cfg_be_in),
    .cfg_wr_in                    (cfg_wr_in),
    .cfg_rd_in                    (cfg_rd_in),
    .cfg_wdata_in                 (cfg_wdata_in),
    .smm_region_lock_in           (smm_region_lock_in),
    .cfg_rdata_out                (cfg_rdata_out),
    .cfg_rvalid_out               (cfg_rvalid_out),
    .frame_buffer_size_select_out (fbs_out),
    .legacy_video_disable_out     (lvd_out),
    .vga_claim_out                (vga_claim_out),
    .sub_class_out                (sub_class_out),
    .unified_memory_out           (uma_out),
    .prealloc_mb_out              (mb_out)
  );

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  // clock generator, 40 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // cuts a hang short, run needs well under 1000 cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // dword image of the register for a size code and disable bit
  function automatic logic [31:0] img(input logic [2:0] code, input logic dis);
    return {9'h000, code, 2'h0, dis, 1'h0, 16'h0000};
  endfunction

  // one write access, strobe held for one edge
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_sys_in);
    cfg_addr_in  <= a;
    cfg_be_in    <= be;
    cfg_wdata_in <= d;
    cfg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    cfg_wr_in    <= 1'b0;
    #1;
  endtask

  // one read access, data checked in its single valid cycle
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in);
    cfg_addr_in <= a;
    cfg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    cfg_rd_in   <= 1'b0;
    #1;
    `CHK(cfg_rvalid_out, 1'b1)
    `CHK(cfg_rdata_out, exp)
  endtask

  // compares all field and decoded outputs against the code table
  task automatic chk_out(input logic [2:0] code, input logic dis);
    logic claim;
    claim = !dis && (code != GMC_FBS_NONE);
    `CHK(fbs_out, code)
    `CHK(lvd_out, dis)
    `CHK(vga_claim_out, claim)
    `CHK(sub_class_out, (claim ? GMC_SUBCLASS_VGA : GMC_SUBCLASS_OTH))
    `CHK(uma_out, (code == GMC_FBS_1MB || code == GMC_FBS_8MB))
    `CHK(mb_out, (code == GMC_FBS_1MB ? GMC_MB_ONE : code == GMC_FBS_8MB ? GMC_MB_EIGHT : GMC_MB_NONE))
  endtask

  // prints counts and verdict, ends the run
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    cycles = 0;
    sys_rst_in = 1'b1;
    cfg_addr_in = 8'h00;
    cfg_be_in = 4'h0;
    cfg_wr_in = 1'b0;
    cfg_rd_in = 1'b0;
    cfg_wdata_in = 32'h0000_0000;
    smm_region_lock_in = 1'b0;
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    // reset values
    cfg_read(8'h50, {GMC_CTRL_RESET, 16'h0000});
    chk_out(GMC_FBS_RESET, GMC_LVD_RESET);
    $display("test reset done");
    // every size code with disable set, then with disable clear (never code zero)
    for (int i = 0; i < 16; i++) begin
      if (i < 8 || i > 8) begin
        cfg_write(8'h50, 4'b0100, img(i[2:0], i < 8));
        cfg_read(8'h50, img(i[2:0], i < 8));
        chk_out(i[2:0], i < 8);
      end
    end
    $display("test codes done");
    // reserved bits ignore writes, lane without the low byte ignored
    cfg_write(8'h50, 4'hf, 32'hffff_ffff);
    cfg_read(8'h50, img(3'h7, 1'b1));
    cfg_write(8'h50, 4'b1011, img(3'h1, 1'b0));
    cfg_read(8'h50, img(3'h7, 1'b1));
    // other dword address neither reads nor writes the register
    cfg_write(8'h54, 4'hf, img(3'h1, 1'b0));
    cfg_read(8'h54, 32'h0000_0000);
    cfg_read(8'h50, img(3'h7, 1'b1));
    $display("test reserved done");
    // lock blocks both fields, release restores writes
    @(posedge clk_sys_in);
    smm_region_lock_in <= 1'b1;
    cfg_write(8'h50, 4'hf, img(3'h1, 1'b0));
    cfg_read(8'h50, img(3'h7, 1'b1));
    chk_out(3'h7, 1'b1);
    @(posedge clk_sys_in);
    smm_region_lock_in <= 1'b0;
    cfg_write(8'h50, 4'b0100, img(3'h3, 1'b0));
    cfg_read(8'h50, img(3'h3, 1'b0));
    chk_out(3'h3, 1'b0);
    $display("test lock done");
    // read and write in one cycle, read shows the old value
    @(posedge clk_sys_in);
    cfg_addr_in <= 8'h50;
    cfg_be_in <= 4'b0100;
    cfg_wdata_in <= img(3'h1, 1'b0);
    cfg_wr_in <= 1'b1;
    cfg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    cfg_wr_in <= 1'b0;
    cfg_rd_in <= 1'b0;
    #1;
    `CHK(cfg_rdata_out, img(3'h3, 1'b0))
    chk_out(3'h1, 1'b0);
    $display("test overlap done");
    // reset in mid-run brings back the reset image
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    #1;
    chk_out(GMC_FBS_RESET, GMC_LVD_RESET);
    cfg_read(8'h50, {GMC_CTRL_RESET, 16'h0000});
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
